// ==== design/pba_pkg.sv ====
// shared constants, types and timing for the bus arbitration and selection ends
package pba_pkg;

  // ****************************************
  // bus shape
  // ****************************************
  localparam int DB_W = 8;
  localparam int ID_W = 3;
  localparam int CTL_W = 6;
  localparam int CTL_BSY = 0;
  localparam int CTL_SEL = 1;
  localparam int CTL_ATN = 2;
  localparam int CTL_IO = 3;
  localparam int CTL_RST = 4;
  localparam int CTL_REQ = 5;

  // ****************************************
  // protocol delays, ns, plain defaults
  // ****************************************
  localparam int CLK_NS = 4;
  localparam int SETTLE_NS = 400;
  localparam int FREE_NS = 800;
  localparam int SET_NS = 1800;
  localparam int CLEAR_NS = 800;
  localparam int ARB_NS = 2400;
  localparam int DESKEW_NS = 45;
  localparam int ABORT_NS = 200000;
  localparam int TIMEOUT_NS = 250000000;
  localparam int RST_HOLD_NS = 25000;

  // minimum times round up, maximum times round down
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FREE_CYC = (FREE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SET_CYC = SET_NS / CLK_NS;
  localparam int CLEAR_CYC = CLEAR_NS / CLK_NS;
  localparam int ARB_CYC = (ARB_NS + CLK_NS - 1) / CLK_NS;
  localparam int DESKEW_CYC = (DESKEW_NS + CLK_NS - 1) / CLK_NS;
  localparam int ABORT_CYC = ABORT_NS / CLK_NS;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic {PBA_TO_RST, PBA_TO_ABORT} pba_tomode_t;

  typedef enum logic [3:0] {
    I_IDLE, I_FREE, I_ARB, I_LOST, I_WON, I_SELD, I_RELB, I_WAITB, I_ACK,
    I_TO_ABORT, I_TO_RST, I_CONN
  } pba_ini_st_t;

  typedef enum logic [2:0] {
    T_IDLE, T_SEEN, T_BSY, T_WSEL, T_CONN, T_IGN
  } pba_tgt_st_t;

endpackage : pba_pkg

// ==== design/pba_bus_if.sv ====
// wired-or bus joining the arbitrating initiator end and the target end
`timescale 1ns/1ns
`default_nettype none
interface pba_bus_if;
  import pba_pkg::*;

  // per party: out level, oe low while driving
  logic [DB_W-1:0] i_db_o, i_db_oe_b, t_db_o, t_db_oe_b;
  logic i_dbp_o, i_dbp_oe_b, t_dbp_o, t_dbp_oe_b;
  logic [CTL_W-1:0] i_ctl_o, i_ctl_oe_b, t_ctl_o, t_ctl_oe_b;

  // resolved levels, true = asserted; released lines read false
  logic [DB_W-1:0] db;
  logic dbp;
  logic [CTL_W-1:0] ctl;

  assign db = (i_db_o & ~i_db_oe_b) | (t_db_o & ~t_db_oe_b);
  assign dbp = (i_dbp_o & ~i_dbp_oe_b) | (t_dbp_o & ~t_dbp_oe_b);
  assign ctl = (i_ctl_o & ~i_ctl_oe_b) | (t_ctl_o & ~t_ctl_oe_b);

  modport ini (
    output i_db_o, i_db_oe_b, i_dbp_o, i_dbp_oe_b, i_ctl_o, i_ctl_oe_b,
    input db, dbp, ctl
  );
  modport tgt (
    output t_db_o, t_db_oe_b, t_dbp_o, t_dbp_oe_b, t_ctl_o, t_ctl_oe_b,
    input db, dbp, ctl
  );
endinterface : pba_bus_if
`default_nettype wire

// ==== design/pba_tmr.sv ====
// saturating cycle counter used to time protocol delays
`timescale 1ns/1ns
`default_nettype none
module pba_tmr #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  output logic [W-1:0] cnt_r
);
  import pba_pkg::*;

  // saturation keeps a stalled wait from wrapping into a false expiry
  always_ff @(posedge clk) begin
    if (!rst_b || clr) begin
      cnt_r <= '0;
    end else if (cnt_r != '1) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule : pba_tmr
`default_nettype wire

// ==== design/pba_ini.sv ====
// arbitrating initiator end: bus free detection, arbitration, selection, time-outs
//
// How it works
// - idle only after settle of BSY,SEL false
// - no driving until bus free delay passes
// - arbitrate with BSY and ID, within set delay
// - after arbitration delay, higher ID bit wins
// - no higher ID seen: won, assert SEL
// - loser drops BSY, ID within clear delay
// - loser waits for SEL before releasing
// - winner holds signals clear plus settle delay
// - arbitration drives own ID only, parity released
// - selection keeps I/O negated
// - drive own plus target ID, assert ATN
// - two deskews, drop BSY, settle, then look
// - target selected: SEL, ID, no BSY, I/O
// - target answers BSY within selection abort time
// - target ignores bad parity or over two IDs
// - two deskews after BSY, release SEL
// - target REQ only after SEL false
// - time-out option: assert bus reset
// - time-out option: keep SEL, ATN, then release
// - responder rechecks selection within abort time
`timescale 1ns/1ns
`default_nettype none
module pba_ini #(
  parameter int OWN_ID = 7,
  parameter int ABORT_N = pba_pkg::ABORT_CYC,
  parameter int TIMEOUT_N = pba_pkg::TIMEOUT_CYC,
  parameter int RST_HOLD_N = pba_pkg::RST_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  pba_bus_if.ini bus,
  input wire logic arb_req,
  input wire logic [pba_pkg::ID_W-1:0] tgt_id,
  input wire pba_pkg::pba_tomode_t to_mode,
  input wire logic disc,
  output logic conn_r,
  output logic won_r,
  output logic lost_r,
  output logic to_r
);
  import pba_pkg::*;

  // ****************************************
  // constants and bus views
  // ****************************************
  localparam logic [DB_W-1:0] OWN_BIT = DB_W'(1) << OWN_ID;
  localparam logic [DB_W:0] ONE_UP = (DB_W + 1)'(1) << (OWN_ID + 1);
  localparam logic [DB_W-1:0] HI_MASK = ~(ONE_UP[DB_W-1:0] - DB_W'(1));

  logic bsy, sel, rst_seen;
  logic [31:0] cnt_r;
  logic tmr_clr;
  pba_ini_st_t st_r, st_nxt;
  logic [DB_W-1:0] sel_db;

  assign bsy = bus.ctl[CTL_BSY];
  assign sel = bus.ctl[CTL_SEL];
  assign rst_seen = bus.ctl[CTL_RST] && (st_r != I_TO_RST);
  assign sel_db = OWN_BIT | (DB_W'(1) << tgt_id);

  // true once n cycles have been spent in the current wait
  function automatic logic reached(input logic [31:0] c, input int n);
    reached = (c >= 32'(n - 1));
  endfunction : reached

  // ****************************************
  // delay timer
  // ****************************************
  // restarts on every state change; in idle also on any BSY/SEL glitch
  assign tmr_clr = (st_nxt != st_r) || ((st_r == I_IDLE) && (bsy || sel));

  pba_tmr #(.W(32)) u_tmr (
    .clk(clk),
    .rst_b(rst_b),
    .clr(tmr_clr),
    .cnt_r(cnt_r)
  );

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      I_IDLE: begin
        if (!bsy && !sel && reached(cnt_r, SETTLE_CYC) && arb_req) begin
          st_nxt = I_FREE;
        end
      end
      I_FREE: begin
        if (bsy || sel) begin
          st_nxt = I_IDLE;
        end else if (reached(cnt_r, FREE_CYC)) begin
          // free delay is shorter than set delay, so this edge is in time
          st_nxt = (cnt_r < 32'(SET_CYC)) ? I_ARB : I_IDLE;
        end
      end
      I_ARB: begin
        if (reached(cnt_r, ARB_CYC)) begin
          st_nxt = |(bus.db & HI_MASK) ? I_LOST : I_WON;
        end
      end
      I_LOST: begin
        // hold BSY and ID until the winner shows SEL, then drop next edge
        if (sel) begin
          st_nxt = I_IDLE;
        end
      end
      I_WON: begin
        if (reached(cnt_r, CLEAR_CYC + SETTLE_CYC)) begin
          st_nxt = I_SELD;
        end
      end
      I_SELD: begin
        if (reached(cnt_r, 2 * DESKEW_CYC)) begin
          st_nxt = I_RELB;
        end
      end
      I_RELB: begin
        if (reached(cnt_r, SETTLE_CYC)) begin
          st_nxt = I_WAITB;
        end
      end
      I_WAITB: begin
        if (bsy) begin
          st_nxt = I_ACK;
        end else if (reached(cnt_r, TIMEOUT_N)) begin
          st_nxt = (to_mode == PBA_TO_RST) ? I_TO_RST : I_TO_ABORT;
        end
      end
      I_ACK: begin
        if (reached(cnt_r, 2 * DESKEW_CYC)) begin
          st_nxt = I_CONN;
        end
      end
      I_TO_ABORT: begin
        if (bsy) begin
          st_nxt = I_ACK;
        end else if (reached(cnt_r, ABORT_N + 2 * DESKEW_CYC)) begin
          st_nxt = I_IDLE;
        end
      end
      I_TO_RST: begin
        if (reached(cnt_r, RST_HOLD_N)) begin
          st_nxt = I_IDLE;
        end
      end
      I_CONN: begin
        if (disc) begin
          st_nxt = I_IDLE;
        end
      end
      default: begin
        st_nxt = I_IDLE;
      end
    endcase
    // a reset from another party aborts whatever is under way
    if (rst_seen) begin
      st_nxt = I_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= I_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // bus drive, registered from the next state
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus.i_db_o <= '0;
      bus.i_db_oe_b <= '1;
      bus.i_dbp_o <= 1'b0;
      bus.i_dbp_oe_b <= 1'b1;
      bus.i_ctl_o <= '0;
      bus.i_ctl_oe_b <= '1;
    end else begin
      bus.i_db_o <= '0;
      bus.i_db_oe_b <= '1;
      bus.i_dbp_o <= 1'b0;
      bus.i_dbp_oe_b <= 1'b1;
      bus.i_ctl_o <= '0;
      bus.i_ctl_oe_b <= '1; // I/O never driven
      unique case (st_nxt)
        I_ARB, I_LOST, I_WON: begin
          bus.i_db_o <= OWN_BIT;
          bus.i_db_oe_b <= ~OWN_BIT;
          bus.i_ctl_o[CTL_BSY] <= 1'b1;
          bus.i_ctl_oe_b[CTL_BSY] <= 1'b0;
          if (st_nxt == I_WON) begin
            bus.i_ctl_o[CTL_SEL] <= 1'b1;
            bus.i_ctl_oe_b[CTL_SEL] <= 1'b0;
          end
        end
        I_SELD, I_RELB, I_WAITB, I_ACK: begin
          bus.i_db_o <= sel_db;
          bus.i_db_oe_b <= '0;
          bus.i_dbp_o <= ~^sel_db;
          bus.i_dbp_oe_b <= 1'b0;
          bus.i_ctl_o[CTL_SEL] <= 1'b1;
          bus.i_ctl_oe_b[CTL_SEL] <= 1'b0;
          bus.i_ctl_o[CTL_ATN] <= 1'b1;
          bus.i_ctl_oe_b[CTL_ATN] <= 1'b0;
          if (st_nxt == I_SELD) begin
            bus.i_ctl_o[CTL_BSY] <= 1'b1;
            bus.i_ctl_oe_b[CTL_BSY] <= 1'b0;
          end
        end
        I_TO_ABORT: begin
          bus.i_ctl_o[CTL_SEL] <= 1'b1;
          bus.i_ctl_oe_b[CTL_SEL] <= 1'b0;
          bus.i_ctl_o[CTL_ATN] <= 1'b1;
          bus.i_ctl_oe_b[CTL_ATN] <= 1'b0;
        end
        I_TO_RST: begin
          bus.i_ctl_o[CTL_RST] <= 1'b1;
          bus.i_ctl_oe_b[CTL_RST] <= 1'b0;
        end
        I_CONN: begin
          // message out follows, so attention stays up
          bus.i_ctl_o[CTL_ATN] <= 1'b1;
          bus.i_ctl_oe_b[CTL_ATN] <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // user status
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      conn_r <= 1'b0;
      won_r <= 1'b0;
      lost_r <= 1'b0;
      to_r <= 1'b0;
    end else begin
      conn_r <= (st_nxt == I_CONN);
      won_r <= (st_r == I_ARB) && (st_nxt == I_WON);
      lost_r <= (st_r == I_ARB) && (st_nxt == I_LOST);
      to_r <= (st_r == I_WAITB) && (st_nxt inside {I_TO_RST, I_TO_ABORT});
    end
  end
endmodule : pba_ini
`default_nettype wire

// ==== design/pba_tgt.sv ====
// target end: selection recognition, validity checks and BSY response
`timescale 1ns/1ns
`default_nettype none
module pba_tgt #(
  parameter int OWN_ID = 0
) (
  input wire logic clk,
  input wire logic rst_b,
  pba_bus_if.tgt bus,
  input wire logic req_in,
  input wire logic release_in,
  output logic conn_r,
  output logic sel_ok_r,
  output logic ign_r,
  output logic [pba_pkg::ID_W-1:0] ini_id_r
);
  import pba_pkg::*;

  localparam logic [DB_W-1:0] OWN_BIT = DB_W'(1) << OWN_ID;

  logic bsy, sel, io, cond, bad;
  logic [31:0] cnt_r;
  logic [ID_W-1:0] ini_enc;
  pba_tgt_st_t st_r, st_nxt;

  assign bsy = bus.ctl[CTL_BSY];
  assign sel = bus.ctl[CTL_SEL];
  assign io = bus.ctl[CTL_IO];
  assign cond = sel && ((bus.db & OWN_BIT) != '0) && !bsy && !io;
  // odd parity over data plus parity bit; more than two ids is invalid
  assign bad = !(^{bus.db, bus.dbp}) || ($countones(bus.db) > 2);

  always_comb begin
    ini_enc = '0;
    for (int i = 0; i < DB_W; i++) begin
      if (bus.db[i] && (i != OWN_ID)) begin
        ini_enc = ID_W'(i);
      end
    end
  end

  pba_tmr #(.W(32)) u_tmr (
    .clk(clk),
    .rst_b(rst_b),
    .clr(st_nxt != st_r),
    .cnt_r(cnt_r)
  );

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      T_IDLE: begin
        if (cond) begin
          st_nxt = T_SEEN;
        end
      end
      T_SEEN: begin
        if (!cond) begin
          st_nxt = T_IDLE;
        end else if (cnt_r >= 32'(SETTLE_CYC - 1)) begin
          // BSY follows one edge later, far inside the abort time
          st_nxt = bad ? T_IGN : T_BSY;
        end
      end
      T_BSY: begin
        // one look after BSY is out: selection must still stand
        st_nxt = sel ? T_WSEL : T_IDLE;
      end
      T_WSEL: begin
        if (!sel) begin
          st_nxt = T_CONN;
        end
      end
      T_CONN: begin
        if (release_in) begin
          st_nxt = T_IDLE;
        end
      end
      T_IGN: begin
        if (!sel) begin
          st_nxt = T_IDLE;
        end
      end
      default: begin
        st_nxt = T_IDLE;
      end
    endcase
    if (bus.ctl[CTL_RST]) begin
      st_nxt = T_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= T_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // bus drive
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus.t_db_o <= '0;
      bus.t_db_oe_b <= '1;
      bus.t_dbp_o <= 1'b0;
      bus.t_dbp_oe_b <= 1'b1;
      bus.t_ctl_o <= '0;
      bus.t_ctl_oe_b <= '1;
    end else begin
      bus.t_db_o <= '0;
      bus.t_db_oe_b <= '1;
      bus.t_dbp_o <= 1'b0;
      bus.t_dbp_oe_b <= 1'b1;
      bus.t_ctl_o <= '0;
      bus.t_ctl_oe_b <= '1;
      if (st_nxt inside {T_BSY, T_WSEL, T_CONN}) begin
        bus.t_ctl_o[CTL_BSY] <= 1'b1;
        bus.t_ctl_oe_b[CTL_BSY] <= 1'b0;
      end
      // transfer handshakes are the user's, gated until SEL is gone
      if ((st_nxt == T_CONN) && req_in && !sel) begin
        bus.t_ctl_o[CTL_REQ] <= 1'b1;
        bus.t_ctl_oe_b[CTL_REQ] <= 1'b0;
      end
    end
  end

  // ****************************************
  // user status
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      conn_r <= 1'b0;
      sel_ok_r <= 1'b0;
      ign_r <= 1'b0;
      ini_id_r <= '0;
    end else begin
      conn_r <= (st_nxt == T_CONN);
      sel_ok_r <= (st_r == T_SEEN) && (st_nxt == T_BSY);
      ign_r <= (st_r == T_SEEN) && (st_nxt == T_IGN);
      if ((st_r == T_SEEN) && (st_nxt == T_BSY)) begin
        ini_id_r <= ini_enc;
      end
    end
  end
endmodule : pba_tgt
`default_nettype wire

// ==== tb/pba_assertions.sv ====
// wire-level checker for the arbitration and selection protocol
`timescale 1ns/1ns
`default_nettype none
module pba_assertions #(
  parameter int OWN_ID = 7,
  parameter int TGT_ID = 0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [pba_pkg::DB_W-1:0] i_db_o,
  input wire logic [pba_pkg::DB_W-1:0] i_db_oe_b,
  input wire logic i_dbp_o,
  input wire logic i_dbp_oe_b,
  input wire logic [pba_pkg::CTL_W-1:0] i_ctl_o,
  input wire logic [pba_pkg::CTL_W-1:0] i_ctl_oe_b,
  input wire logic [pba_pkg::CTL_W-1:0] t_ctl_o,
  input wire logic [pba_pkg::CTL_W-1:0] t_ctl_oe_b,
  input wire logic [pba_pkg::DB_W-1:0] db,
  input wire logic dbp,
  input wire logic [pba_pkg::CTL_W-1:0] ctl
);
  import pba_pkg::*;
  // ********
  // helper counters
  // ********
  // counters are wide ints: long idle stretches must not wrap
  logic [CTL_W-1:0] idrv;
  logic [CTL_W-1:0] tdrv;
  int idle_c, arb_c, sel_c, dat_c, rsp_c, cnd_c;
  assign idrv = i_ctl_o & ~i_ctl_oe_b;
  assign tdrv = t_ctl_o & ~t_ctl_oe_b;
  always_ff @(posedge clk) idle_c <= (!rst_b || ctl[CTL_BSY] || ctl[CTL_SEL]) ? 0 : idle_c + 1;
  always_ff @(posedge clk) arb_c <= (!rst_b || !idrv[CTL_BSY] || idrv[CTL_SEL]) ? 0 : arb_c + 1;
  always_ff @(posedge clk) sel_c <= (!rst_b || !idrv[CTL_SEL]) ? 0 : sel_c + 1;
  always_ff @(posedge clk)
    dat_c <= (!rst_b || !(&{idrv[CTL_SEL], idrv[CTL_ATN], idrv[CTL_BSY]})) ? 0 : dat_c + 1;
  always_ff @(posedge clk)
    rsp_c <= (!rst_b || !(idrv[CTL_SEL] && !idrv[CTL_BSY] && ctl[CTL_BSY])) ? 0 : rsp_c + 1;
  always_ff @(posedge clk)
    cnd_c <= (!rst_b || !(ctl[CTL_SEL] && db[TGT_ID] && !ctl[CTL_BSY] && !ctl[CTL_IO])) ? 0 :
      cnd_c + 1;
  // ********
  // properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_free_then_arb: assert property ($rose(idrv[CTL_BSY]) |->
    idle_c >= SETTLE_CYC + FREE_CYC)
    else $error("arbitration began before bus free and free delay");
  a_arb_own_bit: assert property (idrv[CTL_BSY] && !idrv[CTL_SEL] |->
    i_db_oe_b == ~(8'h01 << OWN_ID) && i_db_o[OWN_ID])
    else $error("arbitration drives other than own id bit");
  a_arb_par_float: assert property (idrv[CTL_BSY] && !idrv[CTL_SEL] |->
    i_dbp_oe_b || i_dbp_o)
    else $error("parity driven false in arbitration");
  a_win_after_arb: assert property ($rose(idrv[CTL_SEL]) |-> arb_c >= ARB_CYC)
    else $error("select asserted before arbitration delay");
  a_win_hold_still: assert property (sel_c >= 1 && sel_c < CLEAR_CYC + SETTLE_CYC |->
    $stable(i_ctl_oe_b) && $stable(i_db_oe_b) && $stable(i_db_o))
    else $error("winner changed signals too early");
  a_sel_io_low: assert property (idrv[CTL_SEL] |-> !ctl[CTL_IO])
    else $error("io asserted during selection");
  a_sel_data_atn: assert property ($fell(idrv[CTL_BSY]) && idrv[CTL_SEL] |->
    idrv[CTL_ATN] && dat_c >= 2 * DESKEW_CYC && db[OWN_ID] &&
    $countones(db) == 2 && ^{db, dbp})
    else $error("selection data, atn or deskew wrong");
  a_tgt_after_settle: assert property ($rose(tdrv[CTL_BSY]) |-> cnd_c >= SETTLE_CYC)
    else $error("target answered before settle");
  // busy reaches the wires one register edge after the settle count
  a_tgt_answer_bound: assert property (cnd_c <= SETTLE_CYC + 1)
    else $error("target late with busy");
  a_tgt_req_late: assert property (tdrv[CTL_REQ] |-> !ctl[CTL_SEL])
    else $error("target request while select true");
  a_ini_sel_drop: assert property ($fell(idrv[CTL_SEL]) && ctl[CTL_BSY] |->
    rsp_c >= 2 * DESKEW_CYC && idrv[CTL_ATN])
    else $error("select released too soon after busy");
  a_abort_release: assert property ($fell(idrv[CTL_SEL]) && !ctl[CTL_BSY] &&
    !ctl[CTL_RST] |-> !idrv[CTL_ATN] && &i_db_oe_b)
    else $error("abort left atn or data driven");
endmodule : pba_assertions
`default_nettype wire

// ==== tb/pba_tb.sv ====
// bench: both ends on one bus, plus two buses where the bench plays a party
`timescale 1ns/1ns
`default_nettype none
module pba_tb;
  import pba_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic arb_req, arb3, disc, req_in, rel, conn_i, won, to, conn_t, ok_t, ok2, ign2, lost3;
  logic [ID_W-1:0] tgt_id;
  logic [ID_W-1:0] id_t;
  logic [ID_W-1:0] id2;
  pba_tomode_t to_mode;
  int n_fail = 0;
  int num_checks = 0;
  int k, c;
  always #2 clk = ~clk;
  pba_bus_if bus();
  pba_bus_if bus2();
  pba_bus_if bus3();
  // shortened time-outs keep the run small
  pba_ini #(.ABORT_N(50), .TIMEOUT_N(200), .RST_HOLD_N(20)) pba_ini_i (.clk(clk), .rst_b(rst_b),
    .bus(bus), .arb_req(arb_req), .tgt_id(tgt_id), .to_mode(to_mode), .disc(disc),
    .conn_r(conn_i), .won_r(won), .lost_r(), .to_r(to));
  pba_tgt pba_tgt_i (.clk(clk), .rst_b(rst_b), .bus(bus), .req_in(req_in), .release_in(rel),
    .conn_r(conn_t), .sel_ok_r(ok_t), .ign_r(), .ini_id_r(id_t));
  pba_tgt pba_tgt_x_i (.clk(clk), .rst_b(rst_b), .bus(bus2), .req_in(req_in), .release_in(rel),
    .conn_r(), .sel_ok_r(ok2), .ign_r(ign2), .ini_id_r(id2));
  pba_ini #(.OWN_ID(6)) pba_ini_x_i (.clk(clk), .rst_b(rst_b), .bus(bus3), .arb_req(arb3),
    .tgt_id(tgt_id), .to_mode(to_mode), .disc(disc), .conn_r(), .won_r(), .lost_r(lost3),
    .to_r());
  pba_assertions pba_assertions_i (.clk(clk), .rst_b(rst_b),
    .i_db_o(bus.i_db_o), .i_db_oe_b(bus.i_db_oe_b), .i_dbp_o(bus.i_dbp_o),
    .i_dbp_oe_b(bus.i_dbp_oe_b), .i_ctl_o(bus.i_ctl_o), .i_ctl_oe_b(bus.i_ctl_oe_b),
    .t_ctl_o(bus.t_ctl_o), .t_ctl_oe_b(bus.t_ctl_oe_b), .db(bus.db), .dbp(bus.dbp),
    .ctl(bus.ctl));
  // ********
  // common tasks
  // ********
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic lim(input int n, input int bound);
    if (n >= bound) begin
      n_fail++;
      complete_run;
    end
  endtask : lim
  task automatic do_reset;
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
  endtask : do_reset
  // bench drives only asserted lines; released lines read false
  task automatic drv2(input logic [7:0] d, input logic p, input logic [5:0] cc);
    bus2.i_db_o = d;
    bus2.i_db_oe_b = ~d;
    bus2.i_dbp_o = p;
    bus2.i_dbp_oe_b = ~p;
    bus2.i_ctl_o = cc;
    bus2.i_ctl_oe_b = ~cc;
  endtask : drv2
  task automatic drv3(input logic [7:0] d, input logic [5:0] cc);
    bus3.t_db_o = d;
    bus3.t_db_oe_b = ~d;
    bus3.t_dbp_o = 1'b0;
    bus3.t_dbp_oe_b = 1'b1;
    bus3.t_ctl_o = cc;
    bus3.t_ctl_oe_b = ~cc;
  endtask : drv3
  // ********
  // scenarios
  // ********
  task automatic sc_select;
    do_reset;
    req_in = 1'b1;
    tgt_id = 3'h0;
    arb_req = 1'b1;
    for (k = 0; k < 1500 && won !== 1'b1; k++) @(negedge clk);
    lim(k, 1500);
    check(bus.db, 8'h80);
    for (k = 0; k < 2000 && ok_t !== 1'b1; k++) @(negedge clk);
    lim(k, 2000);
    check(bus.ctl[CTL_REQ], 1'b0);
    check(id_t, 3'h7);
    for (k = 0; k < 100 && conn_i !== 1'b1; k++) @(negedge clk);
    lim(k, 100);
    repeat (3) @(negedge clk);
    check(conn_t, 1'b1);
    check(bus.ctl, 6'h25);
    arb_req = 1'b0;
    disc = 1'b1;
    rel = 1'b1;
    req_in = 1'b0;
    repeat (4) @(negedge clk);
    check(bus.ctl, 6'h00);
    disc = 1'b0;
    rel = 1'b0;
  endtask : sc_select
  task automatic sc_tmo(input pba_tomode_t m);
    do_reset;
    to_mode = m;
    tgt_id = 3'h3;
    arb_req = 1'b1;
    for (k = 0; k < 3000 && to !== 1'b1; k++) @(negedge clk);
    lim(k, 3000);
    check(k >= 200 + SETTLE_CYC + FREE_CYC + ARB_CYC, 1'b1);
    arb_req = 1'b0;
    // reset is already out in the cycle that shows the time-out pulse
    c = int'(bus.ctl[CTL_RST]);
    if (m == PBA_TO_RST) begin
      for (k = 0; k < 200 && (c == 0 || bus.ctl[CTL_RST]); k++) begin
        @(negedge clk);
        c += bus.ctl[CTL_RST];
      end
      lim(k, 200);
      check(c >= 20, 1'b1);
    end else begin
      @(negedge clk);
      check({bus.ctl[CTL_SEL], bus.ctl[CTL_ATN], bus.db}, 10'h300);
      for (k = 0; k < 200 && bus.ctl[CTL_SEL]; k++) begin
        @(negedge clk);
        c++;
      end
      lim(k, 200);
      check(c >= 50 + 2 * DESKEW_CYC - 1, 1'b1);
    end
    @(negedge clk);
    check(bus.ctl, 6'h00);
  endtask : sc_tmo
  task automatic sc_tsel(input logic [7:0] d, input logic p, input logic good,
                         input logic [2:0] id);
    do_reset;
    drv2(d, p, 6'h02);
    for (k = 0; k < 300 && ok2 !== 1'b1 && ign2 !== 1'b1; k++) @(negedge clk);
    lim(k, 300);
    check({ok2, ign2, bus2.ctl[CTL_BSY]}, {good, !good, good});
    check(id2, id);
    // select dropped at once: the recheck must withdraw busy
    drv2(8'h00, 1'b0, 6'h00);
    repeat (3) @(negedge clk);
    check(bus2.ctl[CTL_BSY], 1'b0);
  endtask : sc_tsel
  task automatic sc_lost;
    do_reset;
    arb3 = 1'b1;
    for (k = 0; k < 400 && bus3.ctl[CTL_BSY] !== 1'b1; k++) @(negedge clk);
    lim(k, 400);
    drv3(8'h80, 6'h01);
    for (k = 0; k < 800 && lost3 !== 1'b1; k++) @(negedge clk);
    lim(k, 800);
    check(bus3.i_dbp_oe_b | bus3.i_dbp_o, 1'b1);
    repeat (5) @(negedge clk);
    check({bus3.i_ctl_oe_b[CTL_BSY], bus3.i_db_oe_b[6]}, 2'b00);
    drv3(8'h80, 6'h03);
    for (k = 0; k < CLEAR_CYC && !(bus3.i_ctl_oe_b[CTL_BSY] & bus3.i_db_oe_b[6]); k++)
      @(negedge clk);
    check(k < CLEAR_CYC, 1'b1);
    arb3 = 1'b0;
    drv3(8'h00, 6'h00);
  endtask : sc_lost
  initial begin
    arb_req = 1'b0;
    arb3 = 1'b0;
    disc = 1'b0;
    req_in = 1'b0;
    rel = 1'b0;
    tgt_id = 3'h0;
    to_mode = PBA_TO_RST;
    drv2(8'h00, 1'b0, 6'h00);
    drv3(8'h00, 6'h00);
    sc_select;
    sc_tmo(PBA_TO_RST);
    sc_tmo(PBA_TO_ABORT);
    sc_tsel(8'h81, 1'b1, 1'b1, 3'h7);
    sc_tsel(8'h01, 1'b0, 1'b1, 3'h0);
    sc_tsel(8'h81, 1'b0, 1'b0, 3'h0);
    sc_tsel(8'h83, 1'b0, 1'b0, 3'h0);
    sc_lost;
    complete_run;
  end
endmodule : pba_tb
`default_nettype wire
